// ---- spi_crc_pkg.sv ----
// Constants for the SPI frame CRC and status layer.
// Assumes a 25 MHz system clock and 32-bit SPI frames with an 8-bit CRC.
package spi_crc_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam int CRC_BITS = 8;
    localparam int CMD_MSB = 31;
    localparam int CMD_LSB = 28;
    localparam int ST_MSB = 27;
    localparam int ST_LSB = 26;
    localparam int SF_MSB = 9;
    localparam int SF_LSB = 8;
    localparam logic [5:0] LAST_BIT = 6'h1F;
    localparam logic [5:0] FULL_COUNT = 6'h20;

    // ----------------------------------------------------------------
    // CRC
    // ----------------------------------------------------------------
    localparam logic [7:0] CRC_POLY = 8'h2F;
    localparam logic [7:0] SEED_DEFAULT = 8'hFF;
    localparam logic [3:0] SEED_UPPER = 4'hF;
    localparam logic [3:0] SEED_ZERO = 4'h0;

    // Bit n set means command nibble n is reserved
    localparam logic [15:0] RESERVED_MASK = 16'h4455;

    // ----------------------------------------------------------------
    // Status encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] ST_INIT = 2'h0;
    localparam logic [1:0] ST_NORMAL = 2'h1;
    localparam logic [1:0] ST_SELF = 2'h2;
    localparam logic [1:0] ST_ERROR = 2'h3;
    localparam logic [1:0] SF_NONE = 2'h0;
    localparam logic [1:0] SF_SPI_ERR = 2'h3;
    localparam logic [3:0] SELF_TEST_OFF = 4'h0;
    localparam int STATUS_SUPPLY_BIT = 7;
    localparam int STATUS_INIT_BIT = 0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SOFT_RESET_WAIT_NS = 1000000;
    localparam int INIT_WAIT_CYCLES = (SOFT_RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Link tracking states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_BUSY = 2'b10
    } link_state_t;

endpackage

// ---- spi_frame_crc_status.sv ----
// SPI target frame layer: command CRC check, reserved command filter,
// response CRC generation and basic/detailed status capture.
// Assumes the upper layer holds respPayload and configuration stable while
// chip select is low, and that sclk idles low and stops between frames.
//
// Summary of operation
// - Command nibbles 0,2,4,6,A,E are reserved; other bits except CRC ignored.
// - A reserved command is answered in the following frame.
// - Reserved reply carries undefined echo and data plus a valid CRC.
// - Every command is checked by an 8-bit CRC over 32 bits, MSB first.
// - A command failing its CRC is dropped and answered with the error reply.
// - Checker preloads seed, shifts all 32 bits; zero remainder means valid.
// - Polynomial 0x2F; seed FF when setting is 0, else F and the setting.
// - Every response frame carries a CRC over its bits, MSB first.
// - Response CRC is seed, message bits, then eight zeros shifted in.
// - Response CRC uses the same polynomial and seed choice as commands.
// - Power-on reset leaves the supply error flag set.
// - After power-on wait, the fourth reply reads 0x6080XXXX.
// - With only the short wait, the fourth reply shows init pending set.
// - Soft reset reloads mirror registers, may set supply error; host waits 1 ms.
// - After soft reset the fourth reply reads 0x6080XXXX.
// - With only the short wait after soft reset, init pending stays set.
// - Each reply's basic status is captured at the previous chip-select release.
// - Status 00 init, 01 normal, 10 self-test, 11 error; detail 00 unless error.
// - Priority: internal error, then self-test, then initialization, then normal.
// - Any SPI error gives basic status 11 with detail marking SPI error.
`timescale 1ns/1ps

module spi_frame_crc_status #(
    parameter int INIT_WAIT_CYCLES = spi_crc_pkg::INIT_WAIT_CYCLES
) (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // SPI link
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    output logic miso,
    output logic misoOe,
    // Configuration and device state
    input wire logic [3:0] crcSeedSetting,
    input wire logic [3:0] selfTestControl,
    input wire logic initDoneFlag,
    input wire logic internalError,
    input wire logic [1:0] internalDetail,
    input wire logic softResetReq,
    input wire logic clearSupplyError,
    // Command and response exchange
    output logic cmdValid,
    output logic [31:0] cmdWord,
    output logic spiError,
    input wire logic [15:0] respPayload,
    // Status
    output logic [1:0] basicStatusField,
    output logic [1:0] detailedStatusField,
    output logic [7:0] deviceStatusReg,
    output logic initPendingBit,
    output logic supplyErrorFlag,
    output logic reloadMirror
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [7:0] crcStep(input logic [7:0] r, input logic b);
        crcStep = {r[6:0], b} ^ (r[7] ? spi_crc_pkg::CRC_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] seedOf(input logic [3:0] setting);
        seedOf = (setting == spi_crc_pkg::SEED_ZERO) ? spi_crc_pkg::SEED_DEFAULT
                                                     : {spi_crc_pkg::SEED_UPPER, setting};
    endfunction

    function automatic logic [7:0] respCrc(input logic [7:0] seed, input logic [23:0] msg);
        logic [7:0] r;
        r = seed;
        for (int i = 23; i >= 0; i--) begin
            r = crcStep(r, msg[i]);
        end
        for (int i = 0; i < spi_crc_pkg::CRC_BITS; i++) begin
            r = crcStep(r, 1'b0);
        end
        respCrc = r;
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    spi_crc_pkg::link_state_t linkState;
    logic [7:0] seedReg;
    logic [31:0] txFrame;
    logic [5:0] bitCount;
    logic [7:0] crcReg;
    logic [31:0] txShift;
    logic [31:0] rxShift;
    logic [31:0] rxWord;
    logic rxOk;
    logic doneToggle;
    logic csMeta, csSync, csPrev;
    logic doneMeta, doneSync, doneSeen;
    logic csFall, csRise, newDone, frameGot, gotNow, okCand;
    logic [31:0] cmdLatch, wordCand;
    logic crcLatch;
    logic errPending, rsvPending;
    logic [3:0] echo;
    logic [1:0] statusNow, detailNow;
    logic [23:0] head;
    logic [31:0] initTimer;
    logic linkIdle;

    // ----------------------------------------------------------------
    // Link domain: receive, check and transmit
    // ----------------------------------------------------------------
    // Chip select high holds the frame counter and checker cleared
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            bitCount <= 6'h00;
            crcReg <= 8'h00;
            txShift <= 32'h0000_0000;
        end else begin
            if (bitCount != spi_crc_pkg::FULL_COUNT) begin
                bitCount <= bitCount + 6'h01;
                crcReg <= crcStep((bitCount == 6'h00) ? seedReg : crcReg, mosi);
            end
            if (bitCount == 6'h00) begin
                txShift <= {txFrame[30:0], 1'b0};
            end else begin
                txShift <= {txShift[30:0], 1'b0};
            end
        end
    end

    // Completed frames are handed over by a toggle
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            rxShift <= 32'h0000_0000;
            rxWord <= 32'h0000_0000;
            rxOk <= 1'b0;
            doneToggle <= 1'b0;
        end else if (!csN && bitCount != spi_crc_pkg::FULL_COUNT) begin
            rxShift <= {rxShift[30:0], mosi};
            if (bitCount == spi_crc_pkg::LAST_BIT) begin
                rxWord <= {rxShift[30:0], mosi};
                rxOk <= (crcStep(crcReg, mosi) == 8'h00);
                doneToggle <= ~doneToggle;
            end
        end
    end

    assign miso = (bitCount == 6'h00) ? txFrame[31] : txShift[31];
    assign misoOe = ~csN;

    // ----------------------------------------------------------------
    // Crossings into the system domain
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            csMeta <= 1'b1;
            csSync <= 1'b1;
            csPrev <= 1'b1;
            doneMeta <= 1'b0;
            doneSync <= 1'b0;
            doneSeen <= 1'b0;
        end else begin
            csMeta <= csN;
            csSync <= csMeta;
            csPrev <= csSync;
            doneMeta <= doneToggle;
            doneSync <= doneMeta;
            doneSeen <= doneSync;
        end
    end

    assign csFall = csPrev & ~csSync;
    assign csRise = ~csPrev & csSync;
    assign newDone = doneSync ^ doneSeen;
    assign gotNow = frameGot | newDone;
    assign wordCand = newDone ? rxWord : cmdLatch;
    assign okCand = newDone ? rxOk : crcLatch;

    // ----------------------------------------------------------------
    // Link tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            linkState <= spi_crc_pkg::LINK_IDLE;
        end else begin
            case (linkState)
                spi_crc_pkg::LINK_IDLE: if (csFall) linkState <= spi_crc_pkg::LINK_BUSY;
                spi_crc_pkg::LINK_BUSY: if (csRise) linkState <= spi_crc_pkg::LINK_IDLE;
                default: linkState <= spi_crc_pkg::LINK_IDLE;
            endcase
        end
    end

    assign linkIdle = (linkState == spi_crc_pkg::LINK_IDLE) && csSync;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frameGot <= 1'b0;
            cmdLatch <= 32'h0000_0000;
            crcLatch <= 1'b0;
        end else begin
            if (newDone) begin
                cmdLatch <= rxWord;
                crcLatch <= rxOk;
            end
            if (csFall) begin
                frameGot <= 1'b0;
            end else if (newDone) begin
                frameGot <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Command acceptance at chip-select release
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmdValid <= 1'b0;
            cmdWord <= 32'h0000_0000;
            spiError <= 1'b0;
            errPending <= 1'b0;
            rsvPending <= 1'b0;
            echo <= 4'h0;
        end else begin
            cmdValid <= 1'b0;
            spiError <= 1'b0;
            if (csRise) begin
                cmdWord <= wordCand;
                echo <= wordCand[spi_crc_pkg::CMD_MSB:spi_crc_pkg::CMD_LSB];
                errPending <= ~(gotNow & okCand);
                spiError <= ~(gotNow & okCand);
                rsvPending <= spi_crc_pkg::RESERVED_MASK[wordCand[31:28]];
                cmdValid <= gotNow & okCand & ~spi_crc_pkg::RESERVED_MASK[wordCand[31:28]];
            end
        end
    end

    // ----------------------------------------------------------------
    // Status encoding and capture
    // ----------------------------------------------------------------
    always_comb begin
        if (internalError) begin
            statusNow = spi_crc_pkg::ST_ERROR;
        end else if (selfTestControl != spi_crc_pkg::SELF_TEST_OFF) begin
            statusNow = spi_crc_pkg::ST_SELF;
        end else if (!initDoneFlag) begin
            statusNow = spi_crc_pkg::ST_INIT;
        end else begin
            statusNow = spi_crc_pkg::ST_NORMAL;
        end
        detailNow = internalError ? internalDetail : spi_crc_pkg::SF_NONE;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            basicStatusField <= spi_crc_pkg::ST_INIT;
            detailedStatusField <= spi_crc_pkg::SF_NONE;
        end else if (csRise) begin
            basicStatusField <= statusNow;
            detailedStatusField <= detailNow;
        end
    end

    // ----------------------------------------------------------------
    // Response frame build, frozen while a frame is in progress
    // ----------------------------------------------------------------
    always_comb begin
        if (errPending) begin
            head = {echo, spi_crc_pkg::ST_ERROR, 16'h0000, spi_crc_pkg::SF_SPI_ERR};
        end else if (rsvPending) begin
            head = {echo, basicStatusField, 16'h0000, detailedStatusField};
        end else begin
            head = {echo, basicStatusField, respPayload, detailedStatusField};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seedReg <= spi_crc_pkg::SEED_DEFAULT;
            txFrame <= 32'h0000_0000;
        end else if (linkIdle) begin
            seedReg <= seedOf(crcSeedSetting);
            txFrame <= {head, respCrc(seedReg, head)};
        end
    end

    // ----------------------------------------------------------------
    // Power-on and soft reset state
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            supplyErrorFlag <= 1'b1;
        end else if (softResetReq) begin
            supplyErrorFlag <= 1'b1;
        end else if (clearSupplyError) begin
            supplyErrorFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || softResetReq) begin
            initPendingBit <= 1'b1;
            initTimer <= 32'(INIT_WAIT_CYCLES);
        end else if (initTimer != 32'h0000_0000) begin
            initTimer <= initTimer - 32'h0000_0001;
        end else begin
            initPendingBit <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reloadMirror <= 1'b0;
            deviceStatusReg <= 8'h00;
        end else begin
            reloadMirror <= softResetReq;
            deviceStatusReg <= 8'h00;
            deviceStatusReg[spi_crc_pkg::STATUS_SUPPLY_BIT] <= supplyErrorFlag;
            deviceStatusReg[spi_crc_pkg::STATUS_INIT_BIT] <= initPendingBit;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    error_priority_a: assert property ((csRise && internalError) |=> basicStatusField == spi_crc_pkg::ST_ERROR)
        else $error("internal error not reported first");
    self_test_a: assert property ((csRise && !internalError && selfTestControl != spi_crc_pkg::SELF_TEST_OFF)
        |=> basicStatusField == spi_crc_pkg::ST_SELF)
        else $error("self-test status wrong");
    init_status_a: assert property ((csRise && !internalError && selfTestControl == spi_crc_pkg::SELF_TEST_OFF
        && !initDoneFlag) |=> basicStatusField == spi_crc_pkg::ST_INIT)
        else $error("init status wrong");
    detail_zero_a: assert property (basicStatusField != spi_crc_pkg::ST_ERROR
        |-> detailedStatusField == spi_crc_pkg::SF_NONE)
        else $error("detail status nonzero without error");
    crc_drop_a: assert property ((csRise && !(gotNow && okCand)) |=> !cmdValid && spiError && errPending)
        else $error("bad command not dropped");
    reserved_drop_a: assert property ((csRise && spi_crc_pkg::RESERVED_MASK[wordCand[31:28]]) |=> !cmdValid)
        else $error("reserved command passed on");
    error_reply_a: assert property ((errPending && linkIdle)[*2] |-> txFrame[27:26] == spi_crc_pkg::ST_ERROR
        && txFrame[9:8] == spi_crc_pkg::SF_SPI_ERR)
        else $error("error reply fields wrong");
    resp_crc_a: assert property ((linkIdle && $past(linkIdle) && !$past(sys_rst) && $stable(seedReg))
        |-> txFrame[7:0] == respCrc(seedReg, txFrame[31:8])) else $error("response crc wrong");
    por_supply_a: assert property (disable iff (1'b0) $past(sys_rst) |-> supplyErrorFlag && initPendingBit)
        else $error("supply error not set after reset");
    seed_load_a: assert property (@(posedge sclk) disable iff (csN)
        (bitCount == 6'h00) |=> crcReg == crcStep(seedOf($past(crcSeedSetting)), $past(mosi)))
        else $error("checker not seeded");
    frame_done_a: assert property (@(negedge sclk) disable iff (csN)
        (bitCount == spi_crc_pkg::FULL_COUNT && $past(bitCount) == spi_crc_pkg::LAST_BIT)
        |-> doneToggle != $past(doneToggle))
        else $error("frame end not signalled");

    accept_c: cover property (cmdValid);
    crc_fail_c: cover property (csRise && gotNow && !okCand);
    reserved_c: cover property (csRise && gotNow && okCand && spi_crc_pkg::RESERVED_MASK[wordCand[31:28]]);
    soft_reset_c: cover property (softResetReq ##1 reloadMirror);

endmodule // spi_frame_crc_status

// ---- spi_host_model.sv ----
// SPI controller model: sends command frames of up to 32 bits MSB first and captures the reply.
// Assumes the target shows bit 31 at chip-select fall and shifts on each sclk rise.
`timescale 1ns/1ps

module spi_host_model (
    // SPI link
    output logic sclk,
    output logic csN,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end

    // Half period 24 ns; sclk stands low outside frames
    task automatic xfer(input logic [31:0] tx, input int nBits, output logic [31:0] rx);
        rx = 32'h0;
        #24 csN = 1'b0;
        for (int i = 0; i < nBits; i++) begin
            mosi = tx[31 - i];
            #24 rx = {rx[30:0], miso};
            sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        // Short frames are left-aligned so the fields keep their places
        rx = rx << (32 - nBits);
        #24 csN = 1'b1;
        // Released line does not keep its last value
        mosi = ~mosi;
    endtask
endmodule // spi_host_model

// ---- spi_frame_crc_and_status_tb.sv ----
// Self-checking bench for the SPI frame CRC and status layer.
// Assumes spi_crc_pkg and spi_host_model are compiled first.
`timescale 1ns/1ps

module spi_frame_crc_and_status_tb;
    localparam int INIT_WAIT = 20;
    logic clk = 1'b0;
    logic sys_rst, sclk, csN, mosi, miso, misoOe;
    logic [3:0] crcSeedSetting, selfTestControl;
    logic initDoneFlag, internalError, softResetReq, clearSupplyError;
    logic [1:0] internalDetail, basicStatusField, detailedStatusField, expST, expSF;
    logic cmdValid, spiError, initPendingBit, supplyErrorFlag, reloadMirror, prevValid, expErr, expNorm, seedChanged;
    logic [31:0] cmdWord;
    logic [15:0] respPayload, expData;
    logic [7:0] deviceStatusReg;
    logic [3:0] expEcho;
    int failCount, checks, seed, okCount, errCount;

    always #20 clk = ~clk;

    spi_frame_crc_status #(.INIT_WAIT_CYCLES(INIT_WAIT)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe),
        .crcSeedSetting(crcSeedSetting), .selfTestControl(selfTestControl), .initDoneFlag(initDoneFlag),
        .internalError(internalError), .internalDetail(internalDetail), .softResetReq(softResetReq),
        .clearSupplyError(clearSupplyError), .cmdValid(cmdValid), .cmdWord(cmdWord), .spiError(spiError),
        .respPayload(respPayload), .basicStatusField(basicStatusField), .detailedStatusField(detailedStatusField),
        .deviceStatusReg(deviceStatusReg), .initPendingBit(initPendingBit), .supplyErrorFlag(supplyErrorFlag),
        .reloadMirror(reloadMirror)
    );

    spi_host_model u_host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

    always @(posedge clk) begin
        if (cmdValid === 1'b1) okCount++;
        if (spiError === 1'b1) errCount++;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", checks, failCount);
        if (failCount == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    function automatic logic [7:0] seedOf(input logic [3:0] s);
        return (s == 4'h0) ? 8'hFF : {4'hF, s};
    endfunction

    // Seed, 24 message bits, then eight zeros
    function automatic logic [7:0] crcOf(input logic [7:0] sd, input logic [23:0] msg);
        logic [7:0] r;
        r = sd;
        for (int i = 0; i < 32; i++)
            r = {r[6:0], (i < 24) ? msg[23 - i] : 1'b0} ^ (r[7] ? 8'h2F : 8'h00);
        return r;
    endfunction

    task automatic waitInit();
        int k;
        k = 0;
        while (initPendingBit !== 1'b0 && k < 40) begin
            tick(1);
            k++;
        end
        if (initPendingBit !== 1'b0) begin
            failCount++;
            results();
        end
    endtask

    // ----------------------------------------------------------------
    // Random frames against the reference model
    // ----------------------------------------------------------------
    task automatic runFrames(input int n);
        logic [31:0] tx, rx;
        logic [3:0] nib;
        logic isRes;
        logic [1:0] stNow, sfNow;
        int kind, bits, okBefore, errBefore;
        for (int f = 0; f < n; f++) begin
            seedChanged = (f % 4 == 0);
            if (seedChanged) begin
                crcSeedSetting = 4'($random(seed));
                tick(3);
            end
            internalError = (($random(seed) & 7) == 0);
            selfTestControl = (($random(seed) & 3) == 0) ? 4'($random(seed)) : 4'h0;
            initDoneFlag = 1'($random(seed));
            internalDetail = 2'($random(seed));
            nib = 4'($random(seed));
            isRes = nib inside {4'h0, 4'h2, 4'h4, 4'h6, 4'hA, 4'hE};
            tx = {nib, 20'($random(seed)), 8'h00};
            tx[7:0] = crcOf(seedOf(crcSeedSetting), tx[31:8]);
            kind = $random(seed) & 7;
            bits = (kind == 1) ? 31 : 32;
            if (kind == 0)
                tx = tx ^ (32'h1 << ($random(seed) & 31));
            okBefore = okCount;
            errBefore = errCount;
            fork
                u_host.xfer(tx, bits, rx);
                begin
                    tick(4);
                    respPayload = 16'($random(seed));
                    check(misoOe, 1'b1);
                end
            join
            tick(10);
            if (prevValid) begin
                check(rx[27:26], expST);
                check(rx[9:8], expSF);
                check(rx[25:10], expData);
                if (expNorm)
                    check(rx[31:28], expEcho);
                if (bits == 32)
                    check(rx[7:0], crcOf(seedOf(crcSeedSetting), rx[31:8]));
            end
            expErr = (kind == 0) || (bits != 32);
            expNorm = !expErr && !isRes;
            check(okCount - okBefore, expNorm ? 1 : 0);
            check(errCount - errBefore, expErr ? 1 : 0);
            if (bits == 32)
                check(cmdWord, tx);
            expEcho = nib;
            stNow = internalError ? 2'h3 : (selfTestControl != 4'h0) ? 2'h2 : initDoneFlag ? 2'h1 : 2'h0;
            sfNow = internalError ? internalDetail : 2'h0;
            expST = expErr ? 2'h3 : stNow;
            expSF = expErr ? 2'h3 : sfNow;
            expData = expNorm ? respPayload : 16'h0;
            check(basicStatusField, stNow);
            check(detailedStatusField, sfNow);
            prevValid = 1'b1;
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic rm;
        seed = 21;
        failCount = 0;
        checks = 0;
        okCount = 0;
        errCount = 0;
        prevValid = 1'b0;
        expNorm = 1'b0;
        sys_rst = 1'b1;
        crcSeedSetting = 4'h0;
        selfTestControl = 4'h0;
        initDoneFlag = 1'b0;
        internalError = 1'b0;
        internalDetail = 2'h0;
        softResetReq = 1'b0;
        clearSupplyError = 1'b0;
        respPayload = 16'h0;
        repeat (12) @(posedge clk);
        #2 sys_rst = 1'b0;
        tick(2);
        check(deviceStatusReg, 8'h81);
        check(misoOe, 1'b0);
        waitInit();
        tick(1);
        check(deviceStatusReg, 8'h80);
        clearSupplyError = 1'b1;
        tick(1);
        clearSupplyError = 1'b0;
        tick(1);
        check(supplyErrorFlag, 1'b0);
        runFrames(60);
        softResetReq = 1'b1;
        tick(1);
        softResetReq = 1'b0;
        rm = reloadMirror;
        tick(1);
        check(rm ^ reloadMirror, 1'b1);
        check(deviceStatusReg, 8'h81);
        prevValid = 1'b0;
        runFrames(4);
        waitInit();
        check(initPendingBit, 1'b0);
        runFrames(30);
        results();
    end

    initial begin
        #3000000;
        failCount++;
        results();
    end
endmodule // spi_frame_crc_and_status_tb
